// *** brs_pkg.sv ***
// Purpose: shared constants for the bus ready and reset sync block
// Assumes: one clock, mclk, each rising edge stands for one falling edge of the system clock
// Notes:   input vector indices, reset values and cycle counts live here
//
// Overview of operation
// - init request low forces system reset high
// - init request synchronized, one-two cycle delay
// - two ready sources, each with own enable
// - sync ready sampled: status idle, half-rate high
// - sync ready and enable low assert ready
// - async pair synchronized, evaluated at half-rate high
// - async pair low asserts ready, sync ignored
// - ready held until status low or inputs inactive
// - ready assertion lasts at least two cycles
// - status low releases the ready driver
// - two cycles released for pull-up recovery
// - active reset forces ready two cycles later
// - ready only pulls low or floats
// - half-rate clock is system clock divided two
// - status low in two cycles holds half-rate high
// - strap selects crystal or external frequency source
package brs_pkg;

  // ---------------------------------------------------------------
  // synchronized input vector layout
  // ---------------------------------------------------------------
  localparam int IN_W       = 10;
  localparam int IX_SYNC_READY_N    = 0;
  localparam int IX_SRDYQ   = 1;
  localparam int IX_ASYNC_READY_N    = 2;
  localparam int IX_ARDYQ   = 3;
  localparam int IX_ST0     = 4;
  localparam int IX_ST1     = 5;
  localparam int IX_INIT    = 6;
  localparam int IX_XTAL    = 7;
  localparam int IX_EFI     = 8;
  localparam int IX_STRAP   = 9;

  // idle levels after reset: actives high, init request asserted
  localparam logic [IN_W-1:0] SYNC_INIT = 10'h03f;

  // ---------------------------------------------------------------
  // timing counts in system clock cycles
  // ---------------------------------------------------------------
  localparam int          READY_MIN_CYC   = 2;
  localparam int          RELEASE_CYC     = 2;
  localparam int          STATUS_HIST_CYC = 2;
  localparam logic [1:0]  MIN_LAST        = 2'(READY_MIN_CYC - 1);
  localparam logic [1:0]  REL_LAST        = 2'(RELEASE_CYC - 1);

  // ---------------------------------------------------------------
  // ready driver states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RDY_IDLE   = 2'b00,
    RDY_PULL   = 2'b01,
    RDY_FLOAT  = 2'b10,
    RDY_FORCED = 2'b11
  } brs_rdy_e;

endpackage : brs_pkg

// *** brs_phase_if.sv ***
// Purpose: carries bus status activity to the half-rate divider and its phase back
// Assumes: both ends on mclk
// Notes:   statusLow is already synchronized
`timescale 1ns/1ns
`default_nettype none
interface brs_phase_if;
  logic statusLow;
  logic halfRate;

  modport div (input statusLow, output halfRate);
  modport ctl (output statusLow, input halfRate);
endinterface : brs_phase_if
`default_nettype wire

// *** brs_sync2.sv ***
// Purpose: two flip-flop synchronizer for a vector of pin levels
// Assumes: bits are independent levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module brs_sync2 #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage1_nxt;
  logic [W-1:0] stage2_nxt;

  always_comb begin
    stage1_nxt = d;
    stage2_nxt = stage1_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_r <= INIT;
      stage2_r <= INIT;
    end else begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign q = stage2_r;

endmodule : brs_sync2
`default_nettype wire

// *** brs_half_rate.sv ***
// Purpose: half-rate phase clock for ready sampling and peripherals
// Assumes: statusLow arrives synchronized
// Notes:   phase realigns during the first bus cycle after reset
`timescale 1ns/1ns
`default_nettype none
module brs_half_rate (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // phase link
  brs_phase_if.div  ph
);

  logic [brs_pkg::STATUS_HIST_CYC-1:0] hist_r;
  logic [brs_pkg::STATUS_HIST_CYC-1:0] hist_nxt;
  logic                                phase_r;
  logic                                phase_nxt;

  always_comb begin
    hist_nxt = {hist_r[brs_pkg::STATUS_HIST_CYC-2:0], ph.statusLow};
    if (|hist_r) begin
      phase_nxt = 1'b1;
    end else begin
      phase_nxt = ~phase_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hist_r  <= '0;
      phase_r <= 1'b0;
    end else begin
      hist_r  <= hist_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign ph.halfRate = phase_r;

endmodule : brs_half_rate
`default_nettype wire

// *** brs_ready_top.sv ***
// Purpose: ready line generation and system reset synchronization
// Assumes: every mclk rising edge stands for one falling system clock edge
// Notes:   ready pin is open drain: out tied low, only the enable moves
`timescale 1ns/1ns
`default_nettype none
module brs_ready_top (
  // clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,

  // reset request
  input  wire logic init_request_n,
  output logic      sysResetOut,

  // ready sources
  input  wire logic sync_ready_n,
  input  wire logic sync_ready_qualify_n,
  input  wire logic async_ready_n,
  input  wire logic async_ready_qualify_n,

  // bus cycle status
  input  wire logic cycle_status_0_n,
  input  wire logic cycle_status_1_n,

  // open-drain ready line
  input  wire logic readyLineIn,
  output logic      readyLineOut,
  output logic      readyLineOe,
  output logic      readyLineLow,

  // clock source
  input  wire logic source_select_strap,
  input  wire logic external_freq_in,
  input  wire logic crystal_pin_a,
  output logic      crystal_pin_b,
  output logic      sysClockOut,
  output logic      half_rate_clock
);

  // ---------------------------------------------------------------
  // input synchronization
  // ---------------------------------------------------------------
  // all pins are asynchronous here, so the synchronous pair also
  // gets two stages; that adds latency but never metastability
  logic [brs_pkg::IN_W-1:0] pinRaw;
  logic [brs_pkg::IN_W-1:0] pinSync;
  logic                     lineSync;

  always_comb begin
    pinRaw                    = '0;
    pinRaw[brs_pkg::IX_SYNC_READY_N]  = sync_ready_n;
    pinRaw[brs_pkg::IX_SRDYQ] = sync_ready_qualify_n;
    pinRaw[brs_pkg::IX_ASYNC_READY_N]  = async_ready_n;
    pinRaw[brs_pkg::IX_ARDYQ] = async_ready_qualify_n;
    pinRaw[brs_pkg::IX_ST0]   = cycle_status_0_n;
    pinRaw[brs_pkg::IX_ST1]   = cycle_status_1_n;
    pinRaw[brs_pkg::IX_INIT]  = init_request_n;
    pinRaw[brs_pkg::IX_XTAL]  = crystal_pin_a;
    pinRaw[brs_pkg::IX_EFI]   = external_freq_in;
    pinRaw[brs_pkg::IX_STRAP] = source_select_strap;
  end

  brs_sync2 #(
    .W    (brs_pkg::IN_W),
    .INIT (brs_pkg::SYNC_INIT)
  ) u_pinSync (
    .clk (mclk),
    .rst (sys_rst),
    .d   (pinRaw),
    .q   (pinSync)
  );

  brs_sync2 #(
    .W    (1),
    .INIT (1'h1)
  ) u_lineSync (
    .clk (mclk),
    .rst (sys_rst),
    .d   (readyLineIn),
    .q   (lineSync)
  );

  brs_phase_if phase ();

  // ---------------------------------------------------------------
  // decoded levels
  // ---------------------------------------------------------------
  logic statusLow;
  logic syncHit;
  logic asyncHit;
  logic readyHit;
  logic sampleOk;

  always_comb begin
    statusLow = ~pinSync[brs_pkg::IX_ST0] | ~pinSync[brs_pkg::IX_ST1];
    syncHit   = ~pinSync[brs_pkg::IX_SYNC_READY_N] & ~pinSync[brs_pkg::IX_SRDYQ];
    asyncHit  = ~pinSync[brs_pkg::IX_ASYNC_READY_N] & ~pinSync[brs_pkg::IX_ARDYQ];
    // async pair decides alone when it hits
    readyHit  = asyncHit ? 1'b1 : syncHit;
    // one sampling point serves both sources
    sampleOk  = phase.halfRate & ~statusLow;
  end

  // ---------------------------------------------------------------
  // half-rate phase clock
  // ---------------------------------------------------------------
  assign phase.statusLow = statusLow;

  brs_half_rate u_halfRate (
    .clk (mclk),
    .rst (sys_rst),
    .ph  (phase.div)
  );

  assign half_rate_clock = phase.halfRate;

  // ---------------------------------------------------------------
  // system reset generation
  // ---------------------------------------------------------------
  logic sysReset_r;
  logic sysReset_nxt;
  logic resetDly_r;
  logic resetDly_nxt;

  always_comb begin
    // the synchronizer already spends the one or two cycle delay
    sysReset_nxt = ~pinSync[brs_pkg::IX_INIT];
    resetDly_nxt = sysReset_r;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sysReset_r <= 1'b1;
      resetDly_r <= 1'b1;
    end else begin
      sysReset_r <= sysReset_nxt;
      resetDly_r <= resetDly_nxt;
    end
  end

  assign sysResetOut = sysReset_r;

  // ---------------------------------------------------------------
  // ready driver state machine
  // ---------------------------------------------------------------
  brs_pkg::brs_rdy_e st_r;
  brs_pkg::brs_rdy_e st_nxt;
  logic [1:0]        cnt_r;
  logic [1:0]        cnt_nxt;
  logic              pull_r;
  logic              pull_nxt;

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    if (resetDly_r) begin
      // forced ready outranks any pending release
      st_nxt  = brs_pkg::RDY_FORCED;
      cnt_nxt = '0;
    end else begin
      unique case (st_r)
        brs_pkg::RDY_IDLE: begin
          if (sampleOk && readyHit) begin
            st_nxt  = brs_pkg::RDY_PULL;
            cnt_nxt = '0;
          end
        end
        brs_pkg::RDY_PULL: begin
          if (cnt_r != brs_pkg::MIN_LAST) begin
            // minimum width holds even against a new status
            cnt_nxt = cnt_r + 2'h1;
          end else if (statusLow) begin
            st_nxt  = brs_pkg::RDY_FLOAT;
            cnt_nxt = '0;
          end else if (sampleOk && !readyHit) begin
            st_nxt  = brs_pkg::RDY_FLOAT;
            cnt_nxt = '0;
          end
        end
        brs_pkg::RDY_FLOAT: begin
          // no new pull while the pull-up restores the line
          if (cnt_r == brs_pkg::REL_LAST) begin
            st_nxt  = brs_pkg::RDY_IDLE;
            cnt_nxt = '0;
          end else begin
            cnt_nxt = cnt_r + 2'h1;
          end
        end
        brs_pkg::RDY_FORCED: begin
          st_nxt  = brs_pkg::RDY_FLOAT;
          cnt_nxt = '0;
        end
      endcase
    end
    pull_nxt = (st_nxt == brs_pkg::RDY_PULL) ||
               (st_nxt == brs_pkg::RDY_FORCED);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r   <= brs_pkg::RDY_FORCED;
      cnt_r  <= '0;
      pull_r <= 1'b1;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      pull_r <= pull_nxt;
    end
  end

  // line only ever pulled low or left floating
  assign readyLineOut = 1'b0;
  assign readyLineOe  = pull_r;
  assign readyLineLow = ~lineSync;

  // ---------------------------------------------------------------
  // clock source selection
  // ---------------------------------------------------------------
  // the strap is caught while system reset stands, once the synchronizer
  // holds the pin level; changing it live is ignored
  logic strap_r;
  logic strap_nxt;
  logic strapTaken_r;
  logic strapTaken_nxt;
  logic sysClk_r;
  logic sysClk_nxt;
  logic xtalDrive_r;
  logic xtalDrive_nxt;

  always_comb begin
    strap_nxt      = strap_r;
    strapTaken_nxt = strapTaken_r | ~sysReset_r;
    if (!strapTaken_r) begin
      strap_nxt = pinSync[brs_pkg::IX_STRAP];
    end
    if (strap_r) begin
      sysClk_nxt = pinSync[brs_pkg::IX_EFI];
    end else begin
      sysClk_nxt = pinSync[brs_pkg::IX_XTAL];
    end
    // inverting stage toward the crystal, unused with external source
    xtalDrive_nxt = ~pinSync[brs_pkg::IX_XTAL] & ~strap_r;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      strap_r      <= 1'b0;
      strapTaken_r <= 1'b0;
      sysClk_r     <= 1'b0;
      xtalDrive_r  <= 1'b0;
    end else begin
      strap_r      <= strap_nxt;
      strapTaken_r <= strapTaken_nxt;
      sysClk_r     <= sysClk_nxt;
      xtalDrive_r  <= xtalDrive_nxt;
    end
  end

  assign sysClockOut   = sysClk_r;
  assign crystal_pin_b = xtalDrive_r;

endmodule : brs_ready_top
`default_nettype wire

// *** brs_ready_props.sv ***
// Purpose: timing checks on the ready line, reset and half-rate outputs
// Assumes: one clock mclk, synchronous reset sys_rst
// Notes:   ready pin latency is three edges through the synchronizers
`timescale 1ns/1ns
`default_nettype none
module brs_ready_props (
  // watched ports
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic init_request_n,
  input wire logic sysResetOut,
  input wire logic sync_ready_n,
  input wire logic sync_ready_qualify_n,
  input wire logic async_ready_n,
  input wire logic async_ready_qualify_n,
  input wire logic cycle_status_0_n,
  input wire logic cycle_status_1_n,
  input wire logic readyLineOut,
  input wire logic readyLineOe,
  input wire logic half_rate_clock
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic stLow = !cycle_status_0_n || !cycle_status_1_n;
  wire logic srcHit = (!sync_ready_n && !sync_ready_qualify_n)
                   || (!async_ready_n && !async_ready_qualify_n);

  a_reset_follows: assert property (!init_request_n [*3] |=> sysResetOut)
    else $error("system reset not raised");
  a_reset_clears: assert property (init_request_n [*3] |=> !sysResetOut)
    else $error("system reset not cleared");
  a_reset_delay: assert property ($rose(sysResetOut) |-> !$past(init_request_n))
    else $error("system reset raised too early");
  a_ready_forced: assert property (sysResetOut [*2] |=> readyLineOe)
    else $error("ready not forced in reset");
  a_open_drain: assert property (!readyLineOut)
    else $error("ready line driven high");
  a_min_width: assert property ($rose(readyLineOe) |=> readyLineOe)
    else $error("ready pulse too short");
  a_status_release: assert property ((stLow && !sysResetOut) [*5] |=> !readyLineOe)
    else $error("ready not released");
  a_float_gap: assert property ($fell(readyLineOe) && !sysResetOut |=> !readyLineOe)
    else $error("ready pulled during recovery");
  a_half_toggle: assert property (!stLow [*6] |-> half_rate_clock != $past(half_rate_clock))
    else $error("half rate clock stuck");
  a_half_hold: assert property (stLow [*4] |=> half_rate_clock)
    else $error("half rate clock not held");
  a_ready_cause: assert property ($rose(readyLineOe) |-> $past(srcHit || !init_request_n, 3))
    else $error("ready without a source");

  c_sync: cover property (!sync_ready_n && !sync_ready_qualify_n ##3 readyLineOe);
  c_async: cover property (!async_ready_n && !async_ready_qualify_n ##3 readyLineOe);
  c_reset: cover property ($fell(sysResetOut));
endmodule : brs_ready_props

bind brs_ready_top brs_ready_props chk_u (
  .mclk, .sys_rst, .init_request_n, .sysResetOut, .sync_ready_n, .sync_ready_qualify_n,
  .async_ready_n, .async_ready_qualify_n, .cycle_status_0_n, .cycle_status_1_n,
  .readyLineOut, .readyLineOe, .half_rate_clock
);
`default_nettype wire

// *** brs_bus_model.sv ***
// Purpose: processor status and address-decoded ready sources
// Assumes: drives on falling edges of mclk
// Notes:   idle lines sit high, as their pull-ups leave them
`timescale 1ns/1ns
`default_nettype none
module brs_bus_model (
  // clock
  input  wire logic mclk,
  // bus status
  output logic      cycle_status_0_n,
  output logic      cycle_status_1_n,
  // ready sources
  output logic      sync_ready_n,
  output logic      sync_ready_qualify_n,
  output logic      async_ready_n,
  output logic      async_ready_qualify_n
);
  initial begin
    {cycle_status_0_n, cycle_status_1_n} = 2'h3;
    {sync_ready_n, sync_ready_qualify_n, async_ready_n, async_ready_qualify_n} = 4'hf;
  end

  // ---------------------------------------------------------------
  // bus cycle: status low two cycles, then one decoded source
  // ---------------------------------------------------------------
  task automatic open_cycle(input logic useAsync, input logic qualN);
    @(negedge mclk);
    // old sources let go as the new cycle starts
    {sync_ready_n, sync_ready_qualify_n, async_ready_n, async_ready_qualify_n} = 4'hf;
    if (useAsync) cycle_status_1_n = 1'b0;
    else cycle_status_0_n = 1'b0;
    repeat (2) @(negedge mclk);
    {cycle_status_0_n, cycle_status_1_n} = 2'h3;
    @(negedge mclk);
    // exactly one source per cycle, its enable level taken from qualN
    if (useAsync) {async_ready_n, async_ready_qualify_n} = {1'b0, qualN};
    else {sync_ready_n, sync_ready_qualify_n} = {1'b0, qualN};
  endtask
endmodule : brs_bus_model
`default_nettype wire

// *** brs_ready_top_tb.sv ***
// Purpose: self-checking bench for the ready and reset block
// Assumes: inputs change on falling edges of mclk
// Notes:   strap moves to the external source in a second reset
`timescale 1ns/1ns
`default_nettype none
module brs_ready_top_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic init_request_n = 1'b1;
  logic source_select_strap = 1'b0;
  logic external_freq_in = 1'b0;
  logic crystal_pin_a = 1'b0;
  logic sync_ready_n, sync_ready_qualify_n, async_ready_n, async_ready_qualify_n;
  logic cycle_status_0_n, cycle_status_1_n;
  logic sysResetOut, readyLineOut, readyLineOe, readyLineLow;
  logic crystal_pin_b, sysClockOut, half_rate_clock;
  // pull-up keeps the released line high
  wire logic readyLineIn = readyLineOe ? readyLineOut : 1'b1;
  int fails = 0;
  int checkCount = 0;
  int cycles = 0;

  always #4 mclk = ~mclk;

  brs_ready_top dut_u (
    .mclk, .sys_rst, .init_request_n, .sysResetOut, .sync_ready_n, .sync_ready_qualify_n,
    .async_ready_n, .async_ready_qualify_n, .cycle_status_0_n, .cycle_status_1_n,
    .readyLineIn, .readyLineOut, .readyLineOe, .readyLineLow, .source_select_strap,
    .external_freq_in, .crystal_pin_a, .crystal_pin_b, .sysClockOut, .half_rate_clock
  );

  brs_bus_model bus (
    .mclk, .cycle_status_0_n, .cycle_status_1_n, .sync_ready_n, .sync_ready_qualify_n,
    .async_ready_n, .async_ready_qualify_n
  );

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input logic got, input logic exp, input string what);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_half();
    logic prev;
    for (int i = 0; i < 4; i++) begin
      prev = half_rate_clock;
      @(negedge mclk);
      check(half_rate_clock, ~prev, "half rate stuck");
    end
  endtask

  task automatic t_clock();
    for (int v = 0; v < 2; v++) begin
      crystal_pin_a = v[0];
      repeat (4) @(negedge mclk);
      check(sysClockOut, v[0], "clock source");
      check(crystal_pin_b, ~v[0], "crystal drive");
    end
  endtask

  task automatic t_ready(input logic useAsync);
    int n;
    n = 0;
    bus.open_cycle(useAsync, 1'b0);
    while (readyLineOe !== 1'b1 && n < 12) begin
      @(negedge mclk);
      n++;
    end
    check(readyLineOe, 1'b1, "ready not asserted");
    repeat (3) @(negedge mclk);
    check(readyLineOe, 1'b1, "ready dropped");
    check(readyLineLow, 1'b1, "line low unseen");
    bus.open_cycle(useAsync, 1'b1);
    repeat (2) @(negedge mclk);
    check(readyLineOe, 1'b0, "ready held");
    repeat (12) @(negedge mclk);
    check(readyLineOe, 1'b0, "unqualified ready");
  endtask

  task automatic t_init_req();
    @(negedge mclk);
    init_request_n = 1'b0;
    @(negedge mclk);
    check(sysResetOut, 1'b0, "reset early");
    repeat (2) @(negedge mclk);
    check(sysResetOut, 1'b1, "reset missing");
    repeat (2) @(negedge mclk);
    check(readyLineOe, 1'b1, "ready not forced");
    init_request_n = 1'b1;
    repeat (12) @(negedge mclk);
    check(sysResetOut, 1'b0, "reset stuck");
    check(readyLineOe, 1'b0, "ready stuck");
  endtask

  task automatic t_strap();
    @(negedge mclk);
    sys_rst = 1'b1;
    source_select_strap = 1'b1;
    repeat (5) @(negedge mclk);
    check(readyLineOe, 1'b1, "ready free in second reset");
    sys_rst = 1'b0;
    repeat (10) @(negedge mclk);
    for (int v = 0; v < 2; v++) begin
      external_freq_in = v[0];
      crystal_pin_a = ~v[0];
      repeat (4) @(negedge mclk);
      check(sysClockOut, v[0], "external source");
      check(crystal_pin_b, 1'b0, "crystal drive off");
    end
  endtask

  initial begin
    repeat (5) @(negedge mclk);
    check(sysResetOut, 1'b1, "reset idle");
    check(readyLineOe, 1'b1, "ready free in reset");
    sys_rst = 1'b0;
    repeat (10) @(negedge mclk);
    check(readyLineOe, 1'b0, "ready not freed");
    t_half();
    t_clock();
    t_ready(1'b0);
    t_ready(1'b1);
    t_init_req();
    t_strap();
    end_of_test();
  end
endmodule : brs_ready_top_tb
`default_nettype wire
